// ---- nmrps_pkg.sv ----
// package: constants and types for the probe pulser and zero-crossing counter
package nmrps_pkg;
  // clock and timing
  localparam int CLK_HZ = 40000000;
  localparam int EXC_NS = 7000;
  localparam int HOLD_NS = 10000;
  localparam int EXC_CYC = (EXC_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int HOLD_CYC = (HOLD_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int REF_HZ = 20000000;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_THRESH = 8'h04;
  localparam logic [7:0] REG_MAXT = 8'h08;
  localparam logic [7:0] REG_XCNT = 8'h0C;
  localparam logic [7:0] REG_TCNT = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_PROBE = 8'h18;
  // control field positions
  localparam int CTRL_WSEL = 0;
  localparam int CTRL_ARM = 1;
  // reset values and bus response codes
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [11:0] THRESH_RST = 12'h064;
  localparam logic [31:0] MAXT_RST = 32'h0003_0D40;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  // width of counters and pulse timer, pulse lengths and probe count
  localparam int CW = 32;
  localparam int TW = 16;
  localparam logic [TW-1:0] EXC_LEN = TW'(EXC_CYC);
  localparam logic [TW-1:0] HOLD_LEN = TW'(HOLD_CYC);
  localparam int NPROBE = 20;

  // counter sequencing states
  typedef enum logic [1:0] {NMRPS_IDLE, NMRPS_WAIT, NMRPS_RUN, NMRPS_DONE}
    nmrps_cstate_t;
endpackage : nmrps_pkg

// ---- nmrps_pulse_if.sv ----
// interface: pulser status toward the counter
`timescale 1ns/1ps
interface nmrps_pulse_if;
  logic excite;
  logic saturation_holdoff;
  logic holdoff_end;
  modport src (output excite, output saturation_holdoff, output holdoff_end);
  modport dst (input excite, input saturation_holdoff, input holdoff_end);
endinterface : nmrps_pulse_if

// ---- nmrps_pulser.sv ----
// module: spin-tip one-shot, excitation width select and saturation hold-off
`timescale 1ns/1ps
module nmrps_pulser
  import nmrps_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // trigger (already synchronised) and width select
  input wire logic trig,
  input wire logic width_from_trig,
  // status out
  nmrps_pulse_if.src pif
);
  typedef struct packed {
    logic trig_p;
    logic [TW-1:0] exc_cnt;
    logic [TW-1:0] hold_cnt;
    logic hold;
  } nmrps_pstate_t;
  nmrps_pstate_t s_q, s_d;
  logic excite;

  // excitation either from one-shot or from trigger level
  assign excite = width_from_trig ? trig : (s_q.exc_cnt != '0);

  // one-shot and hold-off sequencing
  always_comb begin
    s_d = s_q;
    s_d.trig_p = trig;
    if (s_q.exc_cnt != '0) begin
      s_d.exc_cnt = s_q.exc_cnt - TW'(1);
    end
    if (trig && !s_q.trig_p) begin
      s_d.exc_cnt = EXC_LEN;
    end
    if (excite) begin
      s_d.hold = 1'b1;
      s_d.hold_cnt = HOLD_LEN;
    end else if (s_q.hold_cnt != '0) begin
      s_d.hold_cnt = s_q.hold_cnt - TW'(1);
    end else begin
      s_d.hold = 1'b0;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pif.excite = excite;
  assign pif.saturation_holdoff = s_q.hold;
  assign pif.holdoff_end = s_q.hold && !s_d.hold;
endmodule : nmrps_pulser

// ---- nmrps_top.sv ----
// module: probe pulser and zero-crossing frequency counter with AXI4-Lite
// Behaviour
// - rising spin-tip trigger starts a one-shot of the excitation length.
// - a static select picks one-shot or trigger width for excitation.
// - reference carrier passes to amplifier only while excitation active.
// - hold-off stays asserted about 10 us after excitation ends.
// - count crossings until envelope below threshold or max time; code stops on a low decay_envelope pin, thresh unused.
// - count 20 MHz clock ticks over the same interval.
// - both counts start and stop on positive zero crossings.
// - frequency is crossings times clock rate over tick count.
// - decode 5-bit address to select exactly one of 20 probes; addresses 20 to 31 select none.
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module nmrps_top
  import nmrps_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins from sequencer and receiver
  input wire logic spin_tip_trigger,
  input wire logic probe_addr_in_0,
  input wire logic probe_addr_in_1,
  input wire logic probe_addr_in_2,
  input wire logic probe_addr_in_3,
  input wire logic probe_addr_in_4,
  input wire logic decay_signal,
  input wire logic decay_envelope,
  input wire logic ref_carrier,
  input wire logic tick_clk,
  // pins out
  output logic amp_drive,
  output logic saturation_holdoff,
  output logic [NPROBE-1:0] probe_select
);
  typedef struct packed {
    logic [2:0] trig_s, dec_s, env_s, tick_s;
    logic [4:0] addr_a, addr_b, addr_c;
    logic [CW-1:0] ctrl;
    logic [11:0] thresh;
    logic [CW-1:0] maxt;
    logic [CW-1:0] xcnt, tcnt, tmr;
    logic [CW-1:0] xres, tres;
    logic done, overrun, hend;
    nmrps_cstate_t cst;
    logic [4:0] addr;
    logic [NPROBE-1:0] sel;
    logic amp;
    logic aw_h, w_h;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv, rv;
    logic [31:0] rd;
    logic [1:0] rr, br;
  } nmrps_state_t;
  nmrps_state_t s_q, s_d;
  nmrps_pulse_if pif ();
  logic [4:0] addr_raw;
  logic trig_ok, env_ok, dec_rise, tick_rise;
  logic wr_go, rd_go;

  // decode a 5-bit address to a one-hot select, none if out of range
  function automatic logic [NPROBE-1:0] probe_dec(input logic [4:0] a);
    logic [NPROBE-1:0] r;
    r = '0;
    for (int i = 0; i < NPROBE; i++) begin
      if (a == 5'(i)) begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction : probe_dec

  // merge register bytes under strobe
  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  assign addr_raw = {probe_addr_in_4, probe_addr_in_3, probe_addr_in_2,
      probe_addr_in_1, probe_addr_in_0};
  // pin levels taken from stage three as is; edges where stage two is high and stage three low
  assign trig_ok = (s_q.trig_s[1] == s_q.trig_s[2]) ? s_q.trig_s[1]
      : s_q.trig_s[2];
  assign env_ok = s_q.env_s[2];
  assign dec_rise = s_q.dec_s[1] && !s_q.dec_s[2];
  assign tick_rise = s_q.tick_s[1] && !s_q.tick_s[2];

  nmrps_pulser u_pulser (
    .aclk(aclk),
    .aresetn(aresetn),
    .trig(s_q.trig_s[2]),
    .width_from_trig(s_q.ctrl[CTRL_WSEL]),
    .pif(pif)
  );

  assign wr_go = s_q.aw_h && s_q.w_h && !s_q.bv;
  assign rd_go = s_axi_arvalid && !s_q.rv;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    s_d.trig_s = {s_q.trig_s[1:0], spin_tip_trigger};
    s_d.dec_s = {s_q.dec_s[1:0], decay_signal};
    s_d.env_s = {s_q.env_s[1:0], decay_envelope};
    s_d.tick_s = {s_q.tick_s[1:0], tick_clk};
    s_d.addr_a = addr_raw;
    s_d.addr_b = s_q.addr_a;
    s_d.addr_c = s_q.addr_b;
    // latch address only outside acquisition
    if (s_q.addr_b == s_q.addr_c && s_q.cst == NMRPS_IDLE) begin
      s_d.addr = s_q.addr_c;
    end
    s_d.sel = probe_dec(s_q.addr);
    s_d.amp = pif.excite && ref_carrier;
    // zero-crossing measurement
    case (s_q.cst)
      NMRPS_IDLE: begin
        if (s_q.ctrl[CTRL_ARM] && pif.excite) begin
          s_d.cst = NMRPS_WAIT;
          s_d.done = 1'b0;
          s_d.hend = 1'b0;
        end
      end
      NMRPS_WAIT: begin
        // the end of the hold-off pulse opens the start
        if (pif.holdoff_end) begin
          s_d.hend = 1'b1;
        end
        if (s_q.hend && !pif.saturation_holdoff && !pif.excite) begin
          if (dec_rise) begin
            s_d.cst = NMRPS_RUN;
            s_d.xcnt = '0;
            s_d.tcnt = '0;
            s_d.tmr = '0;
          end
        end
      end
      NMRPS_RUN: begin
        s_d.tmr = s_q.tmr + CW'(1);
        if (tick_rise) begin
          s_d.tcnt = s_q.tcnt + CW'(1);
        end
        if (dec_rise) begin
          s_d.xcnt = s_q.xcnt + CW'(1);
          // stop only on a positive crossing
          if (!env_ok || s_q.tmr >= s_q.maxt) begin
            s_d.cst = NMRPS_DONE;
            s_d.xres = s_q.xcnt + CW'(1);
            s_d.tres = s_q.tcnt + (tick_rise ? CW'(1) : CW'(0));
          end
        end
        if (s_q.tcnt == '1) begin
          s_d.overrun = 1'b1;
        end
      end
      NMRPS_DONE: begin
        s_d.done = 1'b1;
        s_d.cst = NMRPS_IDLE;
      end
      default: s_d.cst = NMRPS_IDLE;
    endcase
    // axi write channel capture
    if (s_axi_awvalid && !s_q.aw_h) begin
      s_d.aw_h = 1'b1;
      s_d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_h) begin
      s_d.w_h = 1'b1;
      s_d.wd = s_axi_wdata;
      s_d.ws = s_axi_wstrb;
    end
    if (wr_go) begin
      s_d.aw_h = 1'b0;
      s_d.w_h = 1'b0;
      s_d.bv = 1'b1;
      s_d.br = RESP_OK;
      case (s_q.awa)
        REG_CTRL: s_d.ctrl = merge(s_q.ctrl, s_q.wd, s_q.ws);
        REG_THRESH: s_d.thresh = 12'(merge({20'h0_0000, s_q.thresh},
            s_q.wd, s_q.ws));
        REG_MAXT: s_d.maxt = merge(s_q.maxt, s_q.wd, s_q.ws);
        REG_STAT: begin
          if (s_q.ws[0] && s_q.wd[0] && s_q.cst != NMRPS_DONE) begin
            s_d.done = 1'b0;
          end
          // a run saturating now keeps the flag set
          if (s_q.ws[0] && s_q.wd[1]
              && !(s_q.cst == NMRPS_RUN && s_q.tcnt == '1)) begin
            s_d.overrun = 1'b0;
          end
        end
        default: s_d.br = RESP_ERR;
      endcase
    end
    if (s_q.bv && s_axi_bready) begin
      s_d.bv = 1'b0;
    end
    // axi read
    if (rd_go) begin
      s_d.rv = 1'b1;
      s_d.rr = RESP_OK;
      case (s_axi_araddr)
        REG_CTRL: s_d.rd = s_q.ctrl;
        REG_THRESH: s_d.rd = {20'h0_0000, s_q.thresh};
        REG_MAXT: s_d.rd = s_q.maxt;
        REG_XCNT: s_d.rd = s_q.xres;
        REG_TCNT: s_d.rd = s_q.tres;
        REG_STAT: s_d.rd = {24'h00_0000, pif.saturation_holdoff,
            pif.excite, s_q.cst, env_ok, trig_ok, s_q.overrun, s_q.done};
        REG_PROBE: s_d.rd = {27'h000_0000, s_q.addr};
        default: begin
          s_d.rd = 32'h0000_0000;
          s_d.rr = RESP_ERR;
        end
      endcase
    end
    if (s_q.rv && s_axi_rready) begin
      s_d.rv = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
      s_q.thresh <= THRESH_RST;
      s_q.maxt <= MAXT_RST;
      s_q.cst <= NMRPS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign s_axi_awready = !s_q.aw_h;
  assign s_axi_wready = !s_q.w_h;
  assign s_axi_bvalid = s_q.bv;
  assign s_axi_bresp = s_q.br;
  assign s_axi_arready = !s_q.rv;
  assign s_axi_rvalid = s_q.rv;
  assign s_axi_rdata = s_q.rd;
  assign s_axi_rresp = s_q.rr;
  assign amp_drive = s_q.amp;
  assign saturation_holdoff = pif.saturation_holdoff;
  assign probe_select = s_q.sel;
endmodule : nmrps_top

// ---- nmrps_monitor.sv ----
// checker: bus handshake and pulse timing properties on the top ports
`timescale 1ns/1ps
module nmrps_monitor
  import nmrps_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // pins
  input wire logic spin_tip_trigger,
  input wire logic ref_carrier,
  input wire logic amp_drive,
  input wire logic saturation_holdoff,
  input wire logic [NPROBE-1:0] probe_select
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [9:0] gap_q;
  ////////////////////////////////////////////////////////////
  // cycles since the amplifier was last driven
  always_ff @(posedge aclk) begin
    if (!aresetn) gap_q <= 10'h000;
    else if (amp_drive) gap_q <= 10'h000;
    else if (gap_q != 10'h3FF) gap_q <= gap_q + 10'h001;
  end
  ////////////////////////////////////////////////////////////
  AST_AMP_GATE: assert property (amp_drive |->
    $past(ref_carrier) || $past(ref_carrier, 2)) else $error("amp no carrier");
  AST_AMP_IN_HOLD: assert property ($past(amp_drive) |->
    saturation_holdoff) else $error("amp outside hold-off");
  AST_TRIG_START: assert property ($rose(spin_tip_trigger) &&
    !saturation_holdoff |-> ##[3:8] amp_drive) else $error("no excitation");
  AST_HOLD_RISE: assert property ($rose(spin_tip_trigger) &&
    !saturation_holdoff |-> ##[2:6] saturation_holdoff) else $error("no hold");
  AST_HOLD_TAIL: assert property ($fell(saturation_holdoff) |->
    gap_q inside {[10'h186:10'h19F]}) else $error("hold-off tail length");
  AST_ONE_PROBE: assert property ($onehot0(probe_select))
    else $error("more than one probe");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp dropped");
  AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read not answered");
  cover property ($fell(saturation_holdoff));
  cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata[0]);
  cover property ($rose(amp_drive));
endmodule : nmrps_monitor

bind nmrps_top nmrps_monitor i_nmrps_monitor (.aclk, .aresetn,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .spin_tip_trigger, .ref_carrier,
  .amp_drive, .saturation_holdoff, .probe_select);

// ---- nmrps_far_model.sv ----
// model: receiver side of the pulser mixer, carrier and tick source
`timescale 1ns/1ps
module nmrps_far_model #(
  parameter int HALF = 10
) (
  // clock
  input wire logic aclk,
  // envelope request from the bench
  input wire logic env_on,
  // receiver outputs
  output logic decay_signal,
  output logic decay_envelope,
  output logic tick_clk,
  output logic ref_carrier
);
  int cnt = 0;
  logic [1:0] ph = 2'b00;
  assign decay_envelope = env_on;
  initial begin
    decay_signal = 1'b0;
    tick_clk = 1'b0;
    ref_carrier = 1'b0;
  end
  // lines move on the falling edge, away from the sampling edge
  always @(negedge aclk) begin
    tick_clk <= ~tick_clk;
    ph <= (ph == 2'b10) ? 2'b00 : ph + 2'b01;
    ref_carrier <= (ph == 2'b00);
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) decay_signal <= ~decay_signal;
  end
endmodule : nmrps_far_model

// ---- tb_nmr_probe_sequencer_counter.sv ----
// testbench: pulser timing, probe decode, counters and register access
`timescale 1ns/1ps
`define CHK(a,b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module tb_nmr_probe_sequencer_counter
  import nmrps_pkg::*;
;
  logic aclk = 0, aresetn = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic trig = 0, env_on = 0;
  logic [7:0] aw_a = 0, ar_a = 0;
  logic [31:0] w_d = 0, rd, k, seed;
  logic [4:0] paddr = 0;
  logic [3:0] w_s = 4'hF;
  time ts;
  // ticks of the 20 MHz source in one period of the modelled decay
  localparam int TPP = 20 * REF_HZ / CLK_HZ;
  logic [1:0] rs, b_rs, r_rs;
  logic aw_rd, w_rd, b_v, ar_rd, r_v, dsig, denv, tclk, refc, amp, hold;
  logic [31:0] r_d;
  logic [NPROBE-1:0] psel;
  int err_total = 0, num_checks = 0, hcnt = 0;
  int exp_q[$];
  always #12.5 aclk = ~aclk;
  nmrps_top i_nmrps_top (.aclk, .aresetn, .s_axi_awaddr(aw_a),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_rd), .s_axi_wdata(w_d),
    .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_rd),
    .s_axi_bresp(b_rs), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rd),
    .s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v),
    .s_axi_rready(r_r), .spin_tip_trigger(trig), .probe_addr_in_0(paddr[0]),
    .probe_addr_in_1(paddr[1]), .probe_addr_in_2(paddr[2]),
    .probe_addr_in_3(paddr[3]), .probe_addr_in_4(paddr[4]),
    .decay_signal(dsig), .decay_envelope(denv), .ref_carrier(refc),
    .tick_clk(tclk), .amp_drive(amp), .saturation_holdoff(hold),
    .probe_select(psel));
  nmrps_far_model i_nmrps_far_model (.aclk, .env_on, .decay_signal(dsig),
    .decay_envelope(denv), .tick_clk(tclk), .ref_carrier(refc));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic tmo;
    err_total++;
    end_sim();
  endtask : tmo
  // bus write: address and data offered together, ready for answer on sight
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    bit f = 0;
    aw_a <= a; w_d <= d; aw_v <= 1'b1; w_v <= 1'b1;
    do begin
      @(posedge aclk); n++;
      if (aw_v && aw_rd) aw_v <= 1'b0;
      if (w_v && w_rd) w_v <= 1'b0;
      if (b_v && b_r) f = 1; else if (b_v) b_r <= 1'b1;
    end while (!f && n < 200);
    b_r <= 1'b0; rs = b_rs;
    if (!f) tmo();
  endtask : wr
  // bus read
  task automatic rdr(input logic [7:0] a);
    int n = 0;
    bit f = 0;
    ar_a <= a; ar_v <= 1'b1;
    do begin
      @(posedge aclk); n++;
      if (ar_v && ar_rd) ar_v <= 1'b0;
      if (r_v && r_r) begin f = 1; rd = r_d; rs = r_rs; end
      else if (r_v) r_r <= 1'b1;
    end while (!f && n < 200);
    r_r <= 1'b0;
    if (!f) tmo();
  endtask : rdr
  // trigger of w cycles, expected hold-off length noted for the watcher
  task automatic fire(input int w, input int e);
    int n = 0;
    exp_q.push_back(e);
    trig <= 1'b1;
    repeat (w) @(posedge aclk);
    trig <= 1'b0;
    while (exp_q.size() > 0 && n < 3000) begin @(posedge aclk); n++; end
    if (n >= 3000) tmo();
  endtask : fire
  task automatic wait_done;
    int n = 0;
    do begin rdr(REG_STAT); n++; end while (rd[0] !== 1'b1 && n < 1000);
    if (rd[0] !== 1'b1) tmo();
    ts = $time; // stamp of the measurement set
  endtask : wait_done
  ////////////////////////////////////////////////////////////
  // hold-off length against the oldest expected note
  always @(posedge aclk) begin
    if (hold === 1'b1) hcnt++;
    else if (hcnt > 0) begin
      `CHK(hcnt > exp_q[0] - 5 && hcnt < exp_q[0] + 5, 1'b1)
      void'(exp_q.pop_front());
      hcnt = 0;
    end
  end
  // main sequence
  initial begin
    seed = 32'h0001_2A9C;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(REG_CTRL); `CHK(rd, CTRL_RST)
    rdr(REG_THRESH); `CHK(rd, {20'h0_0000, THRESH_RST})
    rdr(REG_MAXT); `CHK(rd, MAXT_RST)
    rdr(8'h1C); `CHK({rs, rd}, {RESP_ERR, 32'h0000_0000})
    seed = lfsr(seed);
    wr(REG_THRESH, {20'h0_0000, seed[11:0]});
    rdr(REG_THRESH); `CHK(rd[11:0], seed[11:0])
    // byte strobes: only byte one of the threshold changes
    w_s <= 4'h2;
    wr(REG_THRESH, 32'h0000_0F00);
    rdr(REG_THRESH); `CHK(rd[11:0], {4'hF, seed[7:0]})
    w_s <= 4'hF;
    // a read-only counter refuses a write
    wr(REG_XCNT, 32'h0000_0001); `CHK(rs, RESP_ERR)
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      paddr <= (i < 2) ? 5'(19 + i) : seed[4:0];
      repeat (8) @(posedge aclk);
      `CHK(psel, paddr < 5'h14 ? 20'h0_0001 << paddr : 20'h0_0000)
      rdr(REG_PROBE); `CHK(rd[4:0], paddr)
    end
    fire(10, EXC_CYC + HOLD_CYC);
    wr(REG_CTRL, 32'h0000_0001);
    fire(100, 100 + HOLD_CYC);
    wr(REG_CTRL, 32'h0000_0002);
    env_on <= 1'b1;
    fire(10, EXC_CYC + HOLD_CYC);
    repeat (3000) @(posedge aclk);
    env_on <= 1'b0;
    wait_done();
    rdr(REG_XCNT); k = rd;
    `CHK(k > 100 && k < 200, 1'b1)
    rdr(REG_TCNT); `CHK(rd, k * TPP)
    wr(REG_STAT, 32'h0000_0001);
    rdr(REG_STAT); `CHK(rd[0], 1'b0)
    wr(REG_MAXT, 32'h0000_07D0);
    env_on <= 1'b1;
    // random start offset against the decay phase
    seed = lfsr(seed);
    repeat (seed[5:0]) @(posedge aclk);
    fire(10, EXC_CYC + HOLD_CYC);
    wait_done();
    rdr(REG_TCNT); k = rd;
    `CHK(k * 2 > 1996 && k * 2 < 2024, 1'b1)
    // first positive crossing more than 2000 cycles after the start crossing is crossing 101
    rdr(REG_XCNT); `CHK(rd, 32'h0000_0065)
    `CHK(k, rd * TPP)
    `CHK($time - ts < 64'h0000_0000_000F_4240, 1'b1)
    end_sim();
  end
endmodule : tb_nmr_probe_sequencer_counter
